// >>> core/ssi_step_indexer.sv
// Step indexer, power sequencing and set-point table of a stepper driver
`timescale 1ns/1ns
// What this block does
// - Sleep pin low enters sleep within 100 us
// - Sleep pin high resumes running within 10 ms
// - Fault shutdown cleared only by a sleep cycle or by reset
// - Step rising edge advances angle; falling holds
// - Enable high lets both windings drive
// - Enable low switches outputs off, high impedance
// - Direction high forward, low reverse
// - Resolution bits decode full, half a/b, quarter
// - Decode eighth, sixteenth, and two thirty-second codes
// - Sine table, 32 positions per quarter cycle
// - Coarse modes skip positions; half a and full drive diagonals 100 percent
// - Reset returns angle to initial position
// - Angle monitor output marks initial position
module ssi_step_indexer #(
  parameter int unsigned WAKE_CYCLES = ssi_pkg::WAKE_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Host pins, asynchronous
  input wire logic step_clk_i,
  input wire logic direction_select_i,
  input wire logic resolution_select_bit0_i,
  input wire logic resolution_select_bit1_i,
  input wire logic resolution_select_bit2_i,
  input wire logic output_enable_i,
  input wire logic sleep_n_i,
  // Fault detectors, asynchronous
  input wire logic thermal_shutdown_i,
  input wire logic overcurrent_detect_i,
  // Winding drive
  output logic signed [ssi_pkg::PCT_W-1:0] current_a_o,
  output logic signed [ssi_pkg::PCT_W-1:0] current_b_o,
  output logic drive_on_o,
  output logic outputs_hiz_o,
  // Status
  output logic sleep_mode_o,
  output logic ready_o,
  output logic fault_off_o,
  output logic [ssi_pkg::ANGLE_W-1:0] electrical_angle_o,
  output logic angle_monitor_output_o
);
  import ssi_pkg::*;

  // Quarter-wave sine in percent, index 0 to 32
  function automatic logic signed [7:0] sine_pct(input logic [5:0] k);
    logic signed [7:0] v;
    v = PCT_ZERO;
    case (k)
      6'h00: v = 8'sh00;
      6'h01: v = 8'sh05;
      6'h02: v = 8'sh0a;
      6'h03: v = 8'sh0f;
      6'h04: v = 8'sh14;
      6'h05: v = 8'sh18;
      6'h06: v = 8'sh1d;
      6'h07: v = 8'sh22;
      6'h08: v = 8'sh26;
      6'h09: v = 8'sh2b;
      6'h0a: v = 8'sh2f;
      6'h0b: v = 8'sh33;
      6'h0c: v = 8'sh38;
      6'h0d: v = 8'sh3c;
      6'h0e: v = 8'sh3f;
      6'h0f: v = 8'sh43;
      6'h10: v = 8'sh47;
      6'h11: v = 8'sh4a;
      6'h12: v = 8'sh4d;
      6'h13: v = 8'sh50;
      6'h14: v = 8'sh53;
      6'h15: v = 8'sh56;
      6'h16: v = 8'sh58;
      6'h17: v = 8'sh5a;
      6'h18: v = 8'sh5c;
      6'h19: v = 8'sh5e;
      6'h1a: v = 8'sh60;
      6'h1b: v = 8'sh61;
      6'h1c: v = 8'sh62;
      6'h1d: v = 8'sh63;
      default: v = PCT_FULL;
    endcase
    return v;
  endfunction : sine_pct

  // Pin code to mode; both high-high codes give thirty-second
  function automatic ssi_res_type decode_res(input logic [2:0] pins);
    ssi_res_type r;
    r = SSI_RES_FULL;
    case (pins)
      3'h0: r = SSI_RES_FULL;
      3'h4: r = SSI_RES_HALF_A;
      3'h2: r = SSI_RES_HALF_B;
      3'h6: r = SSI_RES_QUARTER;
      3'h1: r = SSI_RES_EIGHTH;
      3'h5: r = SSI_RES_SIXTEENTH;
      default: r = SSI_RES_32ND;
    endcase
    return r;
  endfunction : decode_res

  // Two-stage synchronisers for every pin
  localparam int unsigned NSYNC = 9;
  // Sleep stages reset high: a low start would fake a sleep entry
  localparam logic [NSYNC-1:0] SYNC_IDLE = 9'h040;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  assign pin_raw = {overcurrent_detect_i, thermal_shutdown_i, sleep_n_i,
                    output_enable_i, resolution_select_bit2_i,
                    resolution_select_bit1_i, resolution_select_bit0_i,
                    direction_select_i, step_clk_i};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          sync1_q[gi] <= SYNC_IDLE[gi];
          sync2_q[gi] <= SYNC_IDLE[gi];
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate
  logic step_s;
  logic dir_s;
  logic [2:0] res_pins_s;
  logic enable_s;
  logic sleep_n_s;
  logic fault_s;
  assign step_s = sync2_q[0];
  assign dir_s = sync2_q[1];
  // Bit2 in the top place, as the decode table expects
  assign res_pins_s = {sync2_q[4], sync2_q[3], sync2_q[2]};
  assign enable_s = sync2_q[5];
  assign sleep_n_s = sync2_q[6];
  assign fault_s = sync2_q[7] | sync2_q[8];
  // Power sequencing and fault latch
  ssi_state_type state_q, state_d;
  logic [WAKE_CNT_W-1:0] wake_cnt_q, wake_cnt_d;
  logic fault_q, fault_d;
  always_comb begin
    state_d = state_q;
    wake_cnt_d = wake_cnt_q;
    case (state_q)
      SSI_ST_WAKE: begin
        wake_cnt_d = wake_cnt_q + 1'b1;
        if (!sleep_n_s) begin
          state_d = SSI_ST_SLEEP;
        end else if (wake_cnt_q >= WAKE_CNT_W'(WAKE_CYCLES - 1)) begin
          state_d = SSI_ST_RUN;
        end
      end
      SSI_ST_RUN: begin
        // Sleep entered three cycles after the pin falls
        if (!sleep_n_s) begin
          state_d = SSI_ST_SLEEP;
        end
      end
      SSI_ST_SLEEP: begin
        wake_cnt_d = '0;
        if (sleep_n_s) begin
          state_d = SSI_ST_WAKE;
        end
      end
      default: begin
        state_d = SSI_ST_WAKE;
        wake_cnt_d = '0;
      end
    endcase
    // New fault wins over the clear of a sleep cycle
    fault_d = (fault_q & (state_q != SSI_ST_SLEEP)) | fault_s;
  end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_q <= SSI_ST_WAKE;
      wake_cnt_q <= '0;
      fault_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wake_cnt_q <= wake_cnt_d;
      fault_q <= fault_d;
    end
  end

  // Step indexer
  logic step_prev_q, step_prev_d;
  logic [ANGLE_W-1:0] angle_q, angle_d;
  ssi_res_type res;
  logic [ANGLE_W-1:0] step_size;
  logic [ANGLE_W-1:0] offset;
  logic [ANGLE_W-1:0] rel;
  always_comb begin
    res = decode_res(res_pins_s);
    offset = '0;
    case (res)
      SSI_RES_FULL: begin
        step_size = 7'h20;
        offset = FULL_OFFSET;
      end
      SSI_RES_HALF_A: step_size = 7'h10;
      SSI_RES_HALF_B: step_size = 7'h10;
      SSI_RES_QUARTER: step_size = 7'h08;
      SSI_RES_EIGHTH: step_size = 7'h04;
      SSI_RES_SIXTEENTH: step_size = 7'h02;
      default: step_size = 7'h01;
    endcase
    step_prev_d = step_s;
    angle_d = angle_q;
    // Stepping ignored outside the run state, angle kept
    if (step_s && !step_prev_q && state_q == SSI_ST_RUN) begin
      if (dir_s) begin
        rel = (angle_q - offset) & ~(step_size - 1'b1);
        angle_d = rel + step_size + offset;
      end else begin
        rel = (angle_q - offset + step_size - 1'b1) & ~(step_size - 1'b1);
        angle_d = rel - step_size + offset;
      end
    end else begin
      rel = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      step_prev_q <= 1'b0;
      angle_q <= ANGLE_RESET;
    end else begin
      step_prev_q <= step_prev_d;
      angle_q <= angle_d;
    end
  end
  // Set-point lookup and output gating
  logic signed [PCT_W-1:0] cur_a_q, cur_a_d;
  logic signed [PCT_W-1:0] cur_b_q, cur_b_d;
  logic drive_q, drive_d;
  logic [5:0] k;
  logic [5:0] kc;
  logic signed [PCT_W-1:0] sa;
  logic signed [PCT_W-1:0] sb;
  always_comb begin
    k = {1'b0, angle_q[4:0]};
    kc = QUARTER_LEN - k;
    case (angle_q[6:5])
      2'h0: begin
        sa = sine_pct(kc);
        sb = sine_pct(k);
      end
      2'h1: begin
        sa = -sine_pct(k);
        sb = sine_pct(kc);
      end
      2'h2: begin
        sa = -sine_pct(kc);
        sb = -sine_pct(k);
      end
      default: begin
        sa = sine_pct(k);
        sb = -sine_pct(kc);
      end
    endcase
    // Diagonal of half a and full drives both windings fully
    if ((res == SSI_RES_HALF_A || res == SSI_RES_FULL) &&
        angle_q[4:0] == DIAG_INDEX) begin
      sa = sa[PCT_W-1] ? -PCT_FULL : PCT_FULL;
      sb = sb[PCT_W-1] ? -PCT_FULL : PCT_FULL;
    end
    drive_d = enable_s && state_q == SSI_ST_RUN && !fault_q;
    cur_a_d = drive_d ? sa : PCT_ZERO;
    cur_b_d = drive_d ? sb : PCT_ZERO;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cur_a_q <= PCT_ZERO;
      cur_b_q <= PCT_ZERO;
      drive_q <= 1'b0;
    end else begin
      cur_a_q <= cur_a_d;
      cur_b_q <= cur_b_d;
      drive_q <= drive_d;
    end
  end
  assign current_a_o = cur_a_q;
  assign current_b_o = cur_b_q;
  assign drive_on_o = drive_q;
  assign outputs_hiz_o = !drive_q;
  assign sleep_mode_o = (state_q == SSI_ST_SLEEP);
  assign ready_o = (state_q == SSI_ST_RUN);
  assign fault_off_o = fault_q;
  assign electrical_angle_o = angle_q;
  assign angle_monitor_output_o = (angle_q == ANGLE_RESET);

endmodule : ssi_step_indexer

// >>> core/ssi_pkg.sv
// Constants and types shared by the step indexer
package ssi_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned WAKE_MS = 10;
  localparam int unsigned WAKE_CYC = WAKE_MS * (CLK_HZ / 1000);
  localparam int unsigned WAKE_CNT_W = 17;

  // Electrical angle: 128 positions per cycle at 1/32 step
  localparam int unsigned ANGLE_W = 7;
  localparam logic [6:0] ANGLE_RESET = 7'h00;
  localparam logic [6:0] FULL_OFFSET = 7'h10;
  localparam logic [4:0] DIAG_INDEX = 5'h10;
  localparam logic [5:0] QUARTER_LEN = 6'h20;

  // Set-points in percent, signed
  localparam int unsigned PCT_W = 8;
  localparam logic signed [7:0] PCT_FULL = 8'sh64;
  localparam logic signed [7:0] PCT_ZERO = 8'sh00;

  // Step resolution modes
  typedef enum logic [2:0] {
    SSI_RES_FULL = 3'h0,
    SSI_RES_HALF_A = 3'h1,
    SSI_RES_HALF_B = 3'h2,
    SSI_RES_QUARTER = 3'h3,
    SSI_RES_EIGHTH = 3'h4,
    SSI_RES_SIXTEENTH = 3'h5,
    SSI_RES_32ND = 3'h6
  } ssi_res_type;

  // Power states, Gray coded along wake, run, sleep
  typedef enum logic [1:0] {
    SSI_ST_WAKE = 2'h0,
    SSI_ST_RUN = 2'h1,
    SSI_ST_SLEEP = 2'h3
  } ssi_state_type;

endpackage : ssi_pkg

// >>> testbench/ssi_step_monitor.sv
// Concurrent checks on the step indexer ports
`timescale 1ns/1ns
module ssi_step_monitor #(
  parameter int unsigned WAKE_CYCLES = ssi_pkg::WAKE_CYC
) (
  // Clock, reset and host pins
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic output_enable_i,
  input wire logic sleep_n_i,
  // Design outputs
  input wire logic drive_on_o,
  input wire logic outputs_hiz_o,
  input wire logic sleep_mode_o,
  input wire logic ready_o,
  input wire logic fault_off_o,
  input wire logic [ssi_pkg::ANGLE_W-1:0] electrical_angle_o,
  input wire logic angle_monitor_output_o
);
  import ssi_pkg::*;
  int wait_q;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // Cycles spent waking; slack covers the pin synchronisers
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || ready_o || sleep_mode_o)
      wait_q <= 0;
    else
      wait_q <= wait_q + 1;
  end
  a_hiz_drive: assert property (outputs_hiz_o == !drive_on_o)
    else $error("hiz differs from drive");
  a_enable_off: assert property (
    !output_enable_i [*4] |-> !drive_on_o)
    else $error("drive on while disabled");
  a_sleep_entry: assert property (
    !sleep_n_i [*5] |-> sleep_mode_o && !ready_o && !drive_on_o)
    else $error("sleep not entered");
  a_wake_bound: assert property (wait_q <= WAKE_CYCLES + 4)
    else $error("wake too slow");
  a_fault_held: assert property (
    fault_off_o && !sleep_mode_o |=> fault_off_o)
    else $error("fault dropped without sleep");
  a_fault_drive: assert property (fault_off_o |=> !drive_on_o)
    else $error("drive on during fault");
  a_step_idle: assert property (
    !ready_o |=> $stable(electrical_angle_o))
    else $error("angle moved while not running");
  a_monitor_zero: assert property (
    angle_monitor_output_o == (electrical_angle_o == ANGLE_RESET))
    else $error("monitor wrong");
endmodule : ssi_step_monitor

bind ssi_step_indexer ssi_step_monitor #(.WAKE_CYCLES(WAKE_CYCLES)) i_mon (
  .sys_clk_i, .sys_rst_i, .output_enable_i, .sleep_n_i, .drive_on_o,
  .outputs_hiz_o, .sleep_mode_o, .ready_o, .fault_off_o,
  .electrical_angle_o, .angle_monitor_output_o);

// >>> testbench/ssi_host_model.sv
// Host model driving step, direction and resolution pins
`timescale 1ns/1ns
module ssi_host_model (
  // Clock and request
  input wire logic sys_clk_i,
  input wire logic go_i,
  input wire logic dir_i,
  input wire logic [2:0] mode_i,
  // Pins and status
  output logic step_clk_o,
  output logic direction_select_o = 1'b0,
  output logic [2:0] res_o = 3'h0,
  output logic busy_o
);
  logic [3:0] cnt_q = 4'h0;
  // Pins settle four cycles before the rising step edge
  // Pins move on the falling edge, away from the design's sampling edge
  always @(negedge sys_clk_i) begin
    if (cnt_q != 4'h0)
      cnt_q <= (cnt_q == 4'ha) ? 4'h0 : cnt_q + 4'h1;
    else if (go_i) begin
      cnt_q <= 4'h1;
      direction_select_o <= dir_i;
      res_o <= mode_i;
    end
  end
  // Three cycles high and low, above the capture minimum
  assign step_clk_o = cnt_q >= 4'h5 && cnt_q <= 4'h7;
  assign busy_o = cnt_q != 4'h0;
endmodule : ssi_host_model

// >>> testbench/testbench.sv
// Self-checking bench for the step indexer
`timescale 1ns/1ns
module testbench;
  import ssi_pkg::*;
  localparam int unsigned WK = 20;
  localparam byte S[33] = '{0, 5, 10, 15, 20, 24, 29, 34, 38, 43, 47, 51,
    56, 60, 63, 67, 71, 74, 77, 80, 83, 86, 88, 90, 92, 94, 96, 97, 98, 99,
    100, 100, 100};
  localparam byte Z[8] = '{32, 16, 16, 8, 4, 2, 1, 1};
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, en = 1'b1, slp_n = 1'b1;
  logic th = 1'b0, oc = 1'b0, go = 1'b0, dir = 1'b0;
  logic stp, dsel, busy, drv, hiz, slm, rdy, flt, mon;
  logic [2:0] md = 3'h0, res;
  logic signed [7:0] ca, cb;
  logic [6:0] ang, ea = 7'h00, last = 7'h00;
  logic [22:0] q[$];
  int n_mismatch = 0, compares = 0, cyc = 0, seed = 32'h7eb9;

  always #50 sys_clk_i = ~sys_clk_i;

  ssi_step_indexer #(.WAKE_CYCLES(WK)) i_ssi_step_indexer (.sys_clk_i,
    .sys_rst_i, .step_clk_i(stp), .direction_select_i(dsel),
    .resolution_select_bit0_i(res[2]),
    .resolution_select_bit1_i(res[1]), .resolution_select_bit2_i(res[0]),
    .output_enable_i(en), .sleep_n_i(slp_n), .thermal_shutdown_i(th),
    .overcurrent_detect_i(oc), .current_a_o(ca), .current_b_o(cb),
    .drive_on_o(drv), .outputs_hiz_o(hiz), .sleep_mode_o(slm),
    .ready_o(rdy), .fault_off_o(flt), .electrical_angle_o(ang),
    .angle_monitor_output_o(mon));
  ssi_host_model i_ssi_host_model (.sys_clk_i, .go_i(go), .dir_i(dir),
    .mode_i(md), .step_clk_o(stp), .direction_select_o(dsel),
    .res_o(res), .busy_o(busy));

  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  // Set-points of an angle; half a and full widen the diagonal
  function automatic logic [22:0] expv(logic [6:0] a, logic [2:0] m);
    logic [7:0] c, s;
    c = S[32 - a[4:0]];
    s = S[a[4:0]];
    if (m < 3'h2 && a[4:0] == DIAG_INDEX) begin
      c = PCT_FULL;
      s = PCT_FULL;
    end
    case (a[6:5])
      2'h0: return {a, c, s};
      2'h1: return {a, -s, c};
      2'h2: return {a, -c, -s};
      default: return {a, s, -c};
    endcase
  endfunction : expv

  // Next aligned angle; full step sits on the diagonals
  function automatic logic [6:0] nexta(logic [6:0] a, logic [2:0] m,
                                       logic d);
    logic [6:0] t, z, o;
    z = 7'(Z[m]);
    o = (m == 3'h0) ? FULL_OFFSET : 7'h00;
    t = a - o;
    if (d)
      t = (t & ~(z - 7'h1)) + z;
    else if ((t & (z - 7'h1)) != 7'h00)
      t = t & ~(z - 7'h1);
    else
      t = t - z;
    return t + o;
  endfunction : nexta

  task automatic step(logic [2:0] m, logic d);
    @(negedge sys_clk_i);
    while (busy)
      @(negedge sys_clk_i);
    md <= m;
    dir <= d;
    go <= 1'b1;
    @(negedge sys_clk_i);
    go <= 1'b0;
  endtask : step

  task automatic wake();
    for (int i = 0; i < WK + 8 && rdy !== 1'b1; i++)
      @(negedge sys_clk_i);
    chk(rdy, 8'h01);
    repeat (3) @(negedge sys_clk_i);
  endtask : wake

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // Each angle change takes the oldest note
  initial begin
    logic [22:0] e;
    forever begin
      @(negedge sys_clk_i);
      if (ang !== last) begin
        last = ang;
        e = (q.size() > 0) ? q.pop_front() : 23'h7fffff;
        chk(ang, e[22:16]);
        chk(mon, 8'(ang == 7'h00));
        @(negedge sys_clk_i);
        chk(ca, e[15:8]);
        chk(cb, e[7:0]);
      end
    end
  end

  initial begin
    logic [2:0] m;
    logic d;
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    sys_rst_i <= 1'b0;
    chk(ang, 8'h00);
    chk(mon, 8'h01);
    wake();
    for (int i = 0; i < 48; i++) begin
      m = (i < 16) ? i[2:0] : 3'($random(seed));
      d = 1'($random(seed));
      ea = nexta(ea, m, d);
      q.push_back(expv(ea, m));
      step(m, d);
    end
    repeat (12) @(negedge sys_clk_i);
    en <= 1'b0;
    repeat (5) @(negedge sys_clk_i);
    chk(hiz, 8'h01);
    chk(ca, 8'h00);
    chk(cb, 8'h00);
    en <= 1'b1;
    repeat (5) @(negedge sys_clk_i);
    chk(drv, 8'h01);
    // Each fault, then the sleep cycle that clears it
    for (int f = 0; f < 2; f++) begin
      {oc, th} <= (f == 0) ? 2'h1 : 2'h2;
      repeat (5) @(negedge sys_clk_i);
      {oc, th} <= 2'h0;
      repeat (5) @(negedge sys_clk_i);
      chk(flt, 8'h01);
      chk(drv, 8'h00);
      slp_n <= 1'b0;
      repeat (6) @(negedge sys_clk_i);
      chk(slm, 8'h01);
      chk(rdy, 8'h00);
      step(3'h7, 1'b1);
      repeat (12) @(negedge sys_clk_i);
      slp_n <= 1'b1;
      wake();
      chk(flt, 8'h00);
      chk(drv, 8'h01);
    end
    if (ea != 7'h00)
      q.push_back(23'h0);
    sys_rst_i <= 1'b1;
    repeat (3) @(negedge sys_clk_i);
    sys_rst_i <= 1'b0;
    wake();
    chk(ang, 8'h00);
    ea = nexta(7'h00, 3'h0, 1'b0);
    q.push_back(expv(ea, 3'h0));
    step(3'h0, 1'b0);
    repeat (14) @(negedge sys_clk_i);
    chk(8'(q.size()), 8'h00);
    wrap_up();
  end
endmodule : testbench
